// ### stb_pkg.sv
package stb_pkg;
	// scan register and system word widths
	localparam int IR_W = 8;
	localparam int DR_W = 8;
	localparam int WORD_W = 16;
	// instruction register values
	localparam logic [7:0] IR_CAPTURE = 8'h81;
	localparam logic [7:0] IR_BYPASS = 8'hFF;
	localparam logic [7:0] IR_USER = 8'h02;
	localparam logic [7:0] IR_RESET = 8'hFF;
	// user data register parallel stage after reset
	localparam logic [7:0] USER_RESET = 8'h00;
	// zero loaded into the bypass cell at capture
	localparam logic BYPASS_CAPTURE = 1'b0;
	// controller states
	typedef enum logic [3:0] {
		ST_RESET = 4'h0,
		ST_IDLE = 4'h1,
		ST_SEL_DR = 4'h2,
		ST_CAP_DR = 4'h3,
		ST_SH_DR = 4'h4,
		ST_EX1_DR = 4'h5,
		ST_PAU_DR = 4'h6,
		ST_EX2_DR = 4'h7,
		ST_UPD_DR = 4'h8,
		ST_SEL_IR = 4'h9,
		ST_CAP_IR = 4'hA,
		ST_SH_IR = 4'hB,
		ST_EX1_IR = 4'hC,
		ST_PAU_IR = 4'hD,
		ST_EX2_IR = 4'hE,
		ST_UPD_IR = 4'hF
	} stb_tap_e;
	// word handed to the system side: {instruction, data register}
	typedef logic [15:0] stb_word_t;
endpackage : stb_pkg

// ### stb_stream_if.sv
`timescale 1ns/10ps
`default_nettype none
interface stb_stream_if;
	logic valid;
	logic ready;
	stb_pkg::stb_word_t data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : stb_stream_if
`default_nettype wire

// ### stb_buf2.sv
`timescale 1ns/10ps
`default_nettype none
module stb_buf2 (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// streams
	stb_stream_if.snk in_s,
	stb_stream_if.src out_s
);
	import stb_pkg::*;

	stb_word_t head_reg;
	stb_word_t spare_reg;
	logic head_v_reg;
	logic spare_v_reg;
	logic push;
	logic pop;

	// full when the spare slot is taken; this is what stalls the source
	assign in_s.ready = !spare_v_reg;
	assign out_s.valid = head_v_reg;
	assign out_s.data = head_reg;
	assign push = in_s.valid && !spare_v_reg;
	assign pop = head_v_reg && out_s.ready;

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!resetn) begin
			head_v_reg <= 1'b0;
			spare_v_reg <= 1'b0;
			head_reg <= '0;
			spare_reg <= '0;
		end else if (!head_v_reg || pop) begin
			if (spare_v_reg) begin
				head_reg <= spare_reg;
				head_v_reg <= 1'b1;
				spare_v_reg <= push;
				if (push) begin
					spare_reg <= in_s.data;
				end
			end else begin
				head_v_reg <= push;
				if (push) begin
					head_reg <= in_s.data;
				end
			end
		end else if (push) begin
			spare_reg <= in_s.data;
			spare_v_reg <= 1'b1;
		end
	end
endmodule : stb_buf2
`default_nettype wire

// ### stb_tap.sv
`timescale 1ns/10ps
`default_nettype none
module stb_tap (
	// system clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// scan pins
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	// updated words toward the system
	output logic word_valid,
	input wire logic word_ready,
	output stb_pkg::stb_word_t word_data
);
	import stb_pkg::*;

	stb_tap_e state_reg;
	stb_tap_e state_next;
	logic rst_t1_reg;
	logic rst_t2_reg;
	logic [IR_W-1:0] ir_sh_reg;
	logic [IR_W-1:0] ir_reg;
	logic [DR_W-1:0] user_sh_reg;
	logic [DR_W-1:0] user_reg;
	logic bypass_reg;
	logic tdo_reg;
	logic tdo_oe_reg;
	logic req_tgl_reg;
	stb_word_t xfer_reg;
	logic ack_s1_reg;
	logic ack_s2_reg;
	logic busy;
	logic dr_bit;
	logic user_sel;
	// system side
	logic req_s1_reg;
	logic req_s2_reg;
	logic req_s3_reg;
	logic pend_reg;
	stb_word_t hold_reg;
	logic ack_tgl_reg;

	stb_stream_if fill_s ();
	stb_stream_if drain_s ();

	////////////////////////////////////////////////////////////////////
	// reset into the scan clock domain; needs scan clock edges to act
	always_ff @(posedge tck) begin
		rst_t1_reg <= resetn;
		rst_t2_reg <= rst_t1_reg;
	end

	////////////////////////////////////////////////////////////////////
	// controller: mode select sampled on the rising edge
	always_comb begin
		state_next = ST_RESET;
		case (state_reg)
			ST_RESET: state_next = tms ? ST_RESET : ST_IDLE;
			ST_IDLE: state_next = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: state_next = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: state_next = tms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: state_next = tms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: state_next = tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: state_next = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: state_next = tms ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: state_next = tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: state_next = tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: state_next = tms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: state_next = tms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: state_next = tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: state_next = tms ? ST_SEL_DR : ST_IDLE;
			default: state_next = ST_RESET;
		endcase
	end

	always_ff @(posedge tck) begin
		if (!rst_t2_reg) begin
			state_reg <= ST_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// shifters, rising edge
	assign user_sel = (ir_reg == IR_USER);

	always_ff @(posedge tck) begin
		if (!rst_t2_reg) begin
			ir_sh_reg <= IR_CAPTURE;
		end else if (state_reg == ST_CAP_IR) begin
			ir_sh_reg <= IR_CAPTURE;
		end else if (state_reg == ST_SH_IR) begin
			ir_sh_reg <= {tdi, ir_sh_reg[IR_W-1:1]};
		end
	end

	always_ff @(posedge tck) begin
		if (!rst_t2_reg) begin
			bypass_reg <= BYPASS_CAPTURE;
		end else if (state_reg == ST_CAP_DR) begin
			bypass_reg <= BYPASS_CAPTURE;
		end else if (state_reg == ST_SH_DR) begin
			bypass_reg <= tdi;
		end
	end

	always_ff @(posedge tck) begin
		if (!rst_t2_reg) begin
			user_sh_reg <= USER_RESET;
		end else if (state_reg == ST_CAP_DR && user_sel) begin
			user_sh_reg <= user_reg;
		end else if (state_reg == ST_SH_DR && user_sel) begin
			user_sh_reg <= {tdi, user_sh_reg[DR_W-1:1]};
		end
	end

	////////////////////////////////////////////////////////////////////
	// output pin and update stages, falling edge
	// any instruction other than the user one falls back to bypass
	assign dr_bit = user_sel ? user_sh_reg[0] : bypass_reg;

	always_ff @(negedge tck) begin
		if (!rst_t2_reg) begin
			tdo_reg <= 1'b0;
			tdo_oe_reg <= 1'b0;
		end else begin
			// enable only in shift states; exit-one drops it
			tdo_oe_reg <= (state_reg == ST_SH_IR) ||
				(state_reg == ST_SH_DR);
			if (state_reg == ST_SH_IR) begin
				tdo_reg <= ir_sh_reg[0];
			end else if (state_reg == ST_SH_DR) begin
				tdo_reg <= dr_bit;
			end
		end
	end

	always_ff @(negedge tck) begin
		if (!rst_t2_reg || state_reg == ST_RESET) begin
			ir_reg <= IR_RESET;
		end else if (state_reg == ST_UPD_IR) begin
			ir_reg <= ir_sh_reg;
		end
	end

	always_ff @(negedge tck) begin
		if (!rst_t2_reg) begin
			user_reg <= USER_RESET;
		end else if (state_reg == ST_UPD_DR && user_sel) begin
			user_reg <= user_sh_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// toggle handshake toward the system clock; word held until ack
	always_ff @(posedge tck) begin
		ack_s1_reg <= ack_tgl_reg;
		ack_s2_reg <= ack_s1_reg;
	end

	// an update while the previous word is still unacked is not sent
	assign busy = (req_tgl_reg != ack_s2_reg);

	always_ff @(negedge tck) begin
		if (!rst_t2_reg) begin
			req_tgl_reg <= 1'b0;
			xfer_reg <= '0;
		end else if (state_reg == ST_UPD_DR && !busy) begin
			req_tgl_reg <= !req_tgl_reg;
			xfer_reg <= user_sel ? {ir_reg, user_sh_reg} :
				{ir_reg, {(DR_W-1){1'b0}}, bypass_reg};
		end
	end

	////////////////////////////////////////////////////////////////////
	// system clock side
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			req_s3_reg <= 1'b0;
		end else begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
			req_s3_reg <= req_s2_reg;
		end
	end

	// ack is only returned once the buffer took the word
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pend_reg <= 1'b0;
			hold_reg <= '0;
			ack_tgl_reg <= 1'b0;
		end else if (req_s2_reg != req_s3_reg) begin
			pend_reg <= 1'b1;
			hold_reg <= xfer_reg;
		end else if (pend_reg && fill_s.ready) begin
			pend_reg <= 1'b0;
			ack_tgl_reg <= req_s3_reg;
		end
	end

	assign fill_s.valid = pend_reg;
	assign fill_s.data = hold_reg;
	assign drain_s.ready = word_ready;

	stb_buf2 u_buf (
		.clk(ref_clk),
		.resetn(resetn),
		.in_s(fill_s.snk),
		.out_s(drain_s.src)
	);

	assign word_valid = drain_s.valid;
	assign word_data = drain_s.data;
	assign tdo = tdo_reg;
	assign tdo_oe = tdo_oe_reg;
endmodule : stb_tap
`default_nettype wire

// ### stb_tap_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module stb_tap_assertions (
	// clocks and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// scan pins
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe,
	// word stream
	input wire logic word_valid,
	input wire logic word_ready,
	input wire stb_pkg::stb_word_t word_data
);
	import stb_pkg::*;
	// five ones force reset, so the dr scan that follows runs in bypass
	AST_OE_ON: assert property (@(posedge tck) disable iff (!resetn)
		tms [*5] ##1 !tms ##1 tms ##1 !tms [*2] |=> tdo_oe)
		else $error("tdo not driven in shift");
	AST_BYP_ZERO: assert property (@(posedge tck) disable iff (!resetn)
		tms [*5] ##1 !tms ##1 tms ##1 !tms [*2] |=> tdo == BYPASS_CAPTURE)
		else $error("bypass did not capture zero");
	AST_BYP_DLY: assert property (@(posedge tck) disable iff (!resetn)
		tms [*5] ##1 !tms ##1 tms ##1 !tms [*3] |=> tdo == $past(tdi))
		else $error("bypass delay wrong");
	AST_OE_OFF: assert property (@(posedge tck) disable iff (!resetn)
		tdo_oe && tms |=> !tdo_oe)
		else $error("tdo not released on exit");
	AST_OE_KEEP: assert property (@(posedge tck) disable iff (!resetn)
		tdo_oe && !tms |=> tdo_oe)
		else $error("tdo dropped inside shift");
	// a tck low phase outlasts one ref_clk period
	AST_TDO_FALL: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		$changed(tdo) |-> !tck)
		else $error("tdo moved while tck high");
	AST_OE_FALL: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		$changed(tdo_oe) |-> !tck)
		else $error("tdo enable moved while tck high");
	AST_WV_HOLD: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		word_valid && !word_ready |=> word_valid && $stable(word_data))
		else $error("word changed before taken");
endmodule : stb_tap_assertions
bind stb_tap stb_tap_assertions i_chk (.ref_clk(ref_clk), .resetn(resetn),
	.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
	.word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
`default_nettype wire

// ### stb_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
module stb_ctl_model (
	// scan pins toward the device
	output logic tck,
	output logic tms,
	output logic tdi,
	// observed side
	input wire logic tdo_pin,
	input wire logic tdo_oe
);
	// tck rests low between steps, so it only runs inside frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	task automatic step(input logic m, input logic d, output logic [1:0] r);
		tms = m;
		tdi = d;
		#32 r = {tdo_oe, tdo_pin};
		tck = 1'b1;
		#32 tck = 1'b0;
	endtask : step
endmodule : stb_ctl_model
`default_nettype wire

// ### tb_stb_tap.sv
`timescale 1ns/10ps
`default_nettype none
module tb_stb_tap;
	import stb_pkg::*;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
	err_count++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); \
end end
	logic ref_clk, resetn, tck, tms, tdi, tdo, tdo_oe, word_valid, word_ready;
	logic [1:0] s;
	logic [7:0] prev, r, d;
	stb_word_t word_data;
	stb_word_t q[$];
	int err_count, cmp_count;
	int seed = 32'h4C3D;
	stb_tap i_dut (.ref_clk(ref_clk), .resetn(resetn), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .word_valid(word_valid),
		.word_ready(word_ready), .word_data(word_data));
	// released tdo floats up, as with a pull-up on the board
	stb_ctl_model i_ctl (.tck(tck), .tms(tms), .tdi(tdi),
		.tdo_pin(tdo_oe ? tdo : 1'b1), .tdo_oe(tdo_oe));
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(negedge ref_clk) word_ready <= 1'($random(seed));
	always @(posedge ref_clk) begin
		if (resetn && word_valid && word_ready) q.push_back(word_data);
	end
	function automatic logic [7:0] byp(input logic [7:0] x);
		return {x[6:0], BYPASS_CAPTURE};
	endfunction : byp
	task automatic go(input logic [7:0] m, input int n);
		for (int i = 0; i < n; i++) begin
			i_ctl.step(m[i], 1'b0, s);
			`CHK(s[1], 1'b0)
		end
	endtask : go
	task automatic shift(input int n, input logic [7:0] di, output logic [7:0] o);
		o = '0;
		for (int i = 0; i < n; i++) begin
			i_ctl.step(i == n - 1, di[i], s);
			`CHK(s[1], 1'b1)
			o[i] = s[0];
		end
	endtask : shift
	task automatic scan_ir(input logic [7:0] ir, output logic [7:0] o);
		go(8'h03, 4);
		shift(8, ir, o);
		go(8'h01, 2);
	endtask : scan_ir
	task automatic scan_dr(input int n, input logic [7:0] di,
		input logic [7:0] tl, input int tn, output logic [7:0] o);
		go(8'h01, 3);
		shift(n, di, o);
		go(tl, tn);
	endtask : scan_dr
	// user dr scan split by a stay in pause-dr, then update and idle
	task automatic scan_dr_pause(input logic [7:0] di, output logic [7:0] o);
		logic [7:0] hi;
		go(8'h01, 3);
		shift(4, di, o);
		go(8'h02, 3);
		shift(4, di >> 4, hi);
		o = {hi[3:0], o[3:0]};
		go(8'h01, 2);
	endtask : scan_dr_pause
	task automatic expect_word(input stb_word_t w);
		stb_word_t g;
		for (int i = 0; i < 60 && q.size() == 0; i++) @(posedge ref_clk);
		g = (q.size() > 0) ? q.pop_front() : ~w;
		`CHK(g, w)
	endtask : expect_word
	task automatic final_report;
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		err_count++;
		final_report();
	end
	initial begin
		resetn = 1'b0;
		word_ready = 1'b0;
		// the tck side needs its own edges to see reset
		fork
			repeat (10) @(posedge ref_clk);
			repeat (4) i_ctl.step(1'b1, 1'b0, s);
		join
		@(negedge ref_clk) resetn = 1'b1;
		go(8'h07, 4);
		prev = USER_RESET;
		for (int k = 0; k < 4; k++) begin
			r = (k == 0) ? 8'hFF : 8'($random(seed));
			scan_ir(IR_USER, d);
			`CHK(d, IR_CAPTURE)
			// second pass parks in pause-dr mid-scan; last one
			// leaves through test-logic-reset
			if (k == 1) begin
				scan_dr_pause(r, d);
			end else begin
				scan_dr(8, r, (k == 3) ? 8'h0F : 8'h01, (k == 3) ? 5 : 2, d);
			end
			`CHK(d, prev)
			expect_word({IR_USER, r});
			prev = r;
		end
		r = 8'($random(seed));
		scan_dr(8, r, 8'h01, 2, d);
		`CHK(d, byp(r))
		expect_word({IR_RESET, 7'h00, r[7]});
		scan_ir(IR_BYPASS, d);
		`CHK(d, IR_CAPTURE)
		scan_dr(3, 8'h05, 8'h01, 2, d);
		`CHK(d[2:0], 3'b010)
		expect_word({IR_BYPASS, 8'h01});
		final_report();
	end
endmodule : tb_stb_tap
`default_nettype wire
